// >>> rtl/lcd_seq_pkg.sv
// Purpose: shared constants for the segment LCD command link
// Assumes: 125 MHz reference clock, host and driver on one clock
// Notes: byte codes, field positions, defaults, timing, host register map
package lcd_seq_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int INIT_WAIT_NS = 100000;
  localparam int INIT_WAIT_CYCLES = (INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_QUARTER_NS = 625;
  localparam int SCL_QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // link bytes
  localparam logic [7:0] DEV_WRITE_ADDR = 8'h7c;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hea;
  localparam logic [7:0] CMD_LOW_POWER = 8'hbc;
  localparam logic [7:0] CMD_ON_THIRD_BIAS = 8'hc8;
  localparam logic [7:0] CMD_DISPLAY_OFF = 8'hc0;
  localparam logic [7:0] CMD_ADDR_PREFIX = 8'he8;
  localparam logic [7:0] CMD_ADDR_ZERO = 8'h00;
  // command field positions
  localparam int CONT_BIT = 7;
  localparam int ENABLE_BIT = 3;
  localparam int BIAS_BIT = 2;
  localparam int A5_BIT = 2;
  localparam int SOFT_RESET_BIT = 1;
  localparam int CLK_SEL_BIT = 0;
  localparam int INV_BIT = 2;
  localparam int FRAME_LSB = 3;
  localparam int POWER_LSB = 0;
  localparam int BLINK_LSB = 0;
  localparam int ALLPX_LSB = 0;
  localparam int LOW_ADDR_LSB = 0;
  localparam logic [1:0] GRP_ADDR = 2'h0;
  localparam logic [1:0] GRP_DCTL = 2'h1;
  localparam logic [1:0] GRP_MODE = 2'h2;
  localparam logic [3:0] SYS_PREFIX = 4'hd;
  localparam logic [4:0] BLINK_PREFIX = 5'h1c;
  localparam logic [4:0] ALLPX_PREFIX = 5'h1f;
  // values after reset
  localparam logic [1:0] DEF_FRAME = 2'h0;
  localparam logic [1:0] DEF_POWER = 2'h2;
  localparam logic [1:0] DEF_BLINK = 2'h0;
  localparam logic [1:0] DEF_ALLPX = 2'h0;
  localparam logic [5:0] DEF_START = 6'h00;
  localparam int RAM_WORDS = 36;
  localparam int MAX_DATA_BYTES = 18;
  localparam int DATA_HDR_LEN = 3;
  // host register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] TX_OFFSET = 8'h08;
  localparam int CTRL_STARTUP_BIT = 0;
  localparam int CTRL_OFF_BIT = 1;
  localparam int CTRL_DATA_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_INIT_BIT = 1;
  localparam int ST_NACK_BIT = 2;
  localparam int ST_ROOM_BIT = 3;
  localparam int TX_LAST_BIT = 8;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [1:0] {KIND_STARTUP, KIND_OFF, KIND_DATA} frame_kind_type;
endpackage

// >>> rtl/lcd_link_if.sv
// Purpose: two-wire link between host controller and LCD driver
// Assumes: open-drain data line, clock driven by host only
// Notes: the wire level is resolved here from both enables
`timescale 1ns/1ps
`default_nettype none
interface lcd_link_if;
  logic scl;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic sda_line;
  // pulled high unless a side drives low
  assign sda_line = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
  modport host (output scl, output sda_host_out, output sda_host_oe, input sda_line);
  modport device (input scl, input sda_line, output sda_dev_out, output sda_dev_oe);
endinterface
`default_nettype wire

// >>> rtl/lcd_cmd_device.sv
// Purpose: LCD driver end: link slave, command decoder, display RAM
// Assumes: link clock much slower than ref_clk_in, sampled here
// Notes: write-only slave; read address is not answered
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_device (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  lcd_link_if.device link,
  input wire logic [5:0] ram_rd_addr_in,
  output logic [3:0] ram_rd_data_out,
  output logic display_enable_out,
  output logic bias_select_bit_out,
  output logic [1:0] frame_rate_sel_out,
  output logic inversion_scheme_sel_out,
  output logic [1:0] power_level_sel_out,
  output logic [1:0] blink_rate_sel_out,
  output logic [1:0] all_pixel_mode_out,
  output logic clock_source_select_out,
  output logic address_high_bit_out,
  output logic [5:0] start_address_out
);
  import lcd_seq_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_CMD, M_DATA, M_SKIP} link_mode_type;

  link_mode_type mode_q, mode_d;
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic ack_phase_q;
  logic sda_oe_q;
  logic [4:0] data_cnt_q;
  logic [5:0] ptr_q;
  logic [3:0] ram_q [RAM_WORDS];
  logic [3:0] rd_data_q;
  logic disp_en_q;
  logic bias_q;
  logic [1:0] frame_q;
  logic inv_q;
  logic [1:0] power_q;
  logic [1:0] blink_q;
  logic [1:0] allpx_q;
  logic clk_sel_q;
  logic a5_q;
  logic [5:0] start_q;

  // wraps a display address back into the 36-word space
  function automatic logic [5:0] ram_wrap(input logic [6:0] p);
    ram_wrap = (p >= 7'(RAM_WORDS)) ? 6'(p - 7'(RAM_WORDS)) : p[5:0];
  endfunction

  // edges come from stages 1 and 2, never from the first flop
  wire scl_rise = scl_sync_q[1] && !scl_sync_q[2];
  wire scl_fall = !scl_sync_q[1] && scl_sync_q[2];
  wire scl_high = scl_sync_q[1] && scl_sync_q[2];
  wire start_seen = scl_high && !sda_sync_q[1] && sda_sync_q[2];
  wire stop_seen = scl_high && sda_sync_q[1] && !sda_sync_q[2];
  wire byte_done = scl_fall && (bit_cnt_q == 4'h8) && !ack_phase_q;

  // command decode on the received byte
  wire addr_match = (shift_q == DEV_WRITE_ADDR);
  wire is_sys = (shift_q[6:3] == SYS_PREFIX);
  wire is_blink = (shift_q[6:2] == BLINK_PREFIX);
  wire is_allpx = (shift_q[6:2] == ALLPX_PREFIX);
  wire is_mode = (shift_q[6:5] == GRP_MODE);
  wire is_dctl = (shift_q[6:5] == GRP_DCTL);
  wire is_aset = (shift_q[6:5] == GRP_ADDR);
  wire room = (data_cnt_q < 5'(MAX_DATA_BYTES));
  wire cmd_take = byte_done && (mode_q == M_CMD);
  wire data_wr = byte_done && (mode_q == M_DATA) && room;
  wire soft_rst = cmd_take && is_sys && shift_q[SOFT_RESET_BIT];
  wire enter_data = cmd_take && !shift_q[CONT_BIT];
  wire [5:0] aset_addr = {a5_q, shift_q[LOW_ADDR_LSB +: 5]};
  wire [5:0] new_start = is_aset ? aset_addr : (soft_rst ? DEF_START : start_q);
  wire [5:0] hi_idx = ram_wrap({1'b0, ptr_q} + 7'h01);
  wire lo_ok = (ptr_q < 6'(RAM_WORDS));
  wire hi_ok = (hi_idx < 6'(RAM_WORDS));
  wire ack_take = byte_done && (((mode_q == M_ADDR) && addr_match) ||
                                (mode_q == M_CMD) || ((mode_q == M_DATA) && room));

  // two-flop synchronisers plus one stage for edge finding
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], link.scl};
      sda_sync_q <= {sda_sync_q[1:0], link.sda_line};
    end
  end

  // framing: start and stop override any byte in progress
  always_comb begin
    mode_d = mode_q;
    if (start_seen) begin
      mode_d = M_ADDR;
    end else if (stop_seen) begin
      mode_d = M_IDLE;
    end else if (byte_done) begin
      unique case (mode_q)
        M_ADDR: mode_d = addr_match ? M_CMD : M_SKIP;
        M_CMD: mode_d = shift_q[CONT_BIT] ? M_CMD : M_DATA;
        M_DATA: mode_d = room ? M_DATA : M_SKIP;
        M_IDLE, M_SKIP: mode_d = mode_q;
      endcase
    end
  end

  // bit shifter and acknowledge driver
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      mode_q <= M_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_phase_q <= 1'b0;
      sda_oe_q <= 1'b0;
      data_cnt_q <= 5'h00;
    end else begin
      mode_q <= mode_d;
      if (start_seen || stop_seen) begin
        bit_cnt_q <= 4'h0;
        ack_phase_q <= 1'b0;
        sda_oe_q <= 1'b0;
        data_cnt_q <= 5'h00;
      end else if (byte_done) begin
        ack_phase_q <= 1'b1;
        sda_oe_q <= ack_take;
        if (data_wr) begin
          data_cnt_q <= data_cnt_q + 5'h01;
        end
      end else if (scl_fall && ack_phase_q) begin
        ack_phase_q <= 1'b0;
        sda_oe_q <= 1'b0;
        bit_cnt_q <= 4'h0;
      end else if (scl_rise && (mode_q != M_IDLE) && (bit_cnt_q != 4'h8)) begin
        shift_q <= {shift_q[6:0], sda_sync_q[1]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  // settings change only when their command arrives or on soft reset; others stay
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in || soft_rst) begin
      disp_en_q <= 1'b0;
      bias_q <= 1'b0;
      frame_q <= DEF_FRAME;
      inv_q <= 1'b0;
      power_q <= DEF_POWER;
      blink_q <= DEF_BLINK;
      allpx_q <= DEF_ALLPX;
      start_q <= DEF_START;
      a5_q <= resetn_in && shift_q[A5_BIT];
      clk_sel_q <= resetn_in && shift_q[CLK_SEL_BIT];
    end else if (cmd_take) begin
      if (is_mode) begin
        disp_en_q <= shift_q[ENABLE_BIT];
        bias_q <= shift_q[BIAS_BIT];
      end
      if (is_dctl) begin
        frame_q <= shift_q[FRAME_LSB +: 2];
        inv_q <= shift_q[INV_BIT];
        power_q <= shift_q[POWER_LSB +: 2];
      end
      if (is_sys) begin
        a5_q <= shift_q[A5_BIT];
        clk_sel_q <= shift_q[CLK_SEL_BIT];
      end
      if (is_blink) begin
        blink_q <= shift_q[BLINK_LSB +: 2];
      end
      if (is_allpx) begin
        allpx_q <= shift_q[ALLPX_LSB +: 2];
      end
      if (is_aset) begin
        start_q <= aset_addr;
      end
    end
  end

  // write pointer: loaded on entry to data, two nibbles per byte
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      ptr_q <= DEF_START;
    end else if (enter_data) begin
      ptr_q <= new_start;
    end else if (data_wr) begin
      ptr_q <= ram_wrap({1'b0, ptr_q} + 7'h02);
    end
  end

  // display RAM; low nibble to the pointer address, high nibble to the next one
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < RAM_WORDS; i++) begin
        ram_q[i] <= 4'h0;
      end
      rd_data_q <= 4'h0;
    end else begin
      if (data_wr && lo_ok) begin
        ram_q[ptr_q] <= shift_q[3:0];
      end
      if (data_wr && hi_ok) begin
        ram_q[hi_idx] <= shift_q[7:4];
      end
      // out-of-range reads give zero rather than an array fault
      rd_data_q <= (ram_rd_addr_in < 6'(RAM_WORDS)) ? ram_q[ram_rd_addr_in] : 4'h0;
    end
  end

  // open drain: data only ever pulled low
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = sda_oe_q;
  assign ram_rd_data_out = rd_data_q;
  assign display_enable_out = disp_en_q;
  assign bias_select_bit_out = bias_q;
  assign frame_rate_sel_out = frame_q;
  assign inversion_scheme_sel_out = inv_q;
  assign power_level_sel_out = power_q;
  assign blink_rate_sel_out = blink_q;
  assign all_pixel_mode_out = allpx_q;
  assign clock_source_select_out = clk_sel_q;
  assign address_high_bit_out = a5_q;
  assign start_address_out = start_q;
endmodule
`default_nettype wire

// >>> rtl/lcd_cmd_host.sv
// Purpose: host end: AHB-Lite registers, data FIFO, link master
// Assumes: one word-wide slave, single transfers, OKAY only
// Notes: a full FIFO stalls the bus write until a byte leaves
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lcd_byte_fifo #(
  parameter int WIDTH = lcd_seq_pkg::FIFO_WIDTH,
  parameter int DEPTH = lcd_seq_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_q != (AW + 1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];

  // pointers and fill count
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_in;
        wr_q <= nxt(wr_q);
      end
      if (pop) begin
        rd_q <= nxt(rd_q);
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

module lcd_cmd_host #(
  parameter int INIT_WAIT_CYCLES = lcd_seq_pkg::INIT_WAIT_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  lcd_link_if.host link
);
  import lcd_seq_pkg::*;

  typedef enum logic [2:0] {H_INIT, H_PRE_STOP, H_IDLE, H_START, H_LOAD, H_BIT,
                            H_STOP} host_state_type;

  host_state_type state_q;
  frame_kind_type kind_q;
  frame_kind_type req_kind_q;
  logic [6:0] qcnt_q;
  logic [31:0] init_cnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_idx_q;
  logic [4:0] step_q;
  logic [7:0] cur_q;
  logic last_q;
  logic scl_q;
  logic oe_q;
  logic init_done_q;
  logic nack_q;
  logic [1:0] sda_sync_q;
  logic pend_q;
  logic pend_wr_q;
  logic [7:0] pend_addr_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic req_q;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [FIFO_WIDTH-1:0] fifo_data;

  // fixed bytes of each frame; step 0 is always the write address
  function automatic logic [7:0] seq_byte(input frame_kind_type k, input logic [4:0] s);
    seq_byte = DEV_WRITE_ADDR;
    if (k == KIND_STARTUP && s == 5'h01) seq_byte = CMD_SOFT_RESET;
    if (k == KIND_STARTUP && s == 5'h02) seq_byte = CMD_LOW_POWER;
    if (k == KIND_STARTUP && s == 5'h03) seq_byte = CMD_ON_THIRD_BIAS;
    if (k == KIND_OFF && s == 5'h01) seq_byte = CMD_DISPLAY_OFF;
    if (k == KIND_DATA && s == 5'h01) seq_byte = CMD_ADDR_PREFIX;
    if (k == KIND_DATA && s == 5'h02) seq_byte = CMD_ADDR_ZERO;
  endfunction

  // bus decode
  wire addr_ph = hsel_in && htrans_in[1] && hready_in;
  wire tx_wr = pend_q && pend_wr_q && (pend_addr_q == TX_OFFSET);
  wire ctrl_wr = pend_q && pend_wr_q && (pend_addr_q == CTRL_OFFSET);
  wire stat_wr = pend_q && pend_wr_q && (pend_addr_q == STATUS_OFFSET);
  wire bus_done = pend_q && !(tx_wr && !fifo_in_ready);
  wire nack_clr = bus_done && stat_wr && hwdata_in[ST_NACK_BIT];
  wire busy = (state_q != H_IDLE) || req_q;
  wire go_ok = bus_done && ctrl_wr && (state_q == H_IDLE) && !req_q && (hwdata_in[2:0] != 3'h0);
  wire take = (state_q == H_IDLE) && req_q;
  wire [31:0] status_val = {28'h0000000, fifo_in_ready, nack_q, init_done_q, busy};
  wire [31:0] rd_val = (pend_addr_q == STATUS_OFFSET) ? status_val : 32'h00000000;

  // engine decode; all-pixel, blink and high address are never sent
  wire tick = (qcnt_q == 7'(SCL_QUARTER_CYCLES - 1));
  wire [4:0] seq_len = (kind_q == KIND_STARTUP) ? 5'h04 : (kind_q == KIND_OFF) ? 5'h02
                       : 5'(DATA_HDR_LEN);
  wire from_fifo = (kind_q == KIND_DATA) && (step_q >= 5'(DATA_HDR_LEN));
  wire frame_done = (kind_q != KIND_DATA) ? (step_q == seq_len)
                    : (last_q || step_q == 5'(DATA_HDR_LEN + MAX_DATA_BYTES));
  wire fifo_pop = (state_q == H_LOAD) && !frame_done && from_fifo;
  wire ack_fail = (state_q == H_BIT) && tick && (ph_q == 2'h2) && (bit_idx_q == 4'h8)
                  && sda_sync_q[1];

  lcd_byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) data_fifo (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(tx_wr),
    .in_ready_out(fifo_in_ready),
    .in_data_in(hwdata_in[FIFO_WIDTH-1:0]),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data)
  );

  // slave: one wait state, longer while the FIFO is full
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      pend_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_addr_q <= 8'h00;
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
      req_q <= 1'b0;
      req_kind_q <= KIND_STARTUP;
    end else begin
      if (addr_ph) begin
        pend_q <= 1'b1;
        pend_wr_q <= hwrite_in;
        pend_addr_q <= haddr_in[7:0];
        hready_q <= 1'b0;
      end else if (bus_done) begin
        pend_q <= 1'b0;
        hready_q <= 1'b1;
        hrdata_q <= pend_wr_q ? 32'h00000000 : rd_val;
      end
      if (go_ok) begin
        req_q <= 1'b1;
        req_kind_q <= hwdata_in[CTRL_STARTUP_BIT] ? KIND_STARTUP
                      : (hwdata_in[CTRL_OFF_BIT] ? KIND_OFF : KIND_DATA);
      end else if (take) begin
        req_q <= 1'b0;
      end
    end
  end

  // free-running quarter-bit divider and acknowledge synchroniser
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      qcnt_q <= 7'h00;
      sda_sync_q <= 2'h3;
    end else begin
      qcnt_q <= tick ? 7'h00 : qcnt_q + 7'h01;
      sda_sync_q <= {sda_sync_q[0], link.sda_line};
    end
  end

  // link master; set-wins for the sticky no-acknowledge flag
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_q <= H_INIT;
      kind_q <= KIND_STARTUP;
      init_cnt_q <= 32'h00000000;
      ph_q <= 2'h0;
      bit_idx_q <= 4'h0;
      step_q <= 5'h00;
      cur_q <= 8'h00;
      last_q <= 1'b0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      init_done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      nack_q <= ack_fail || (nack_q && !nack_clr);
      unique case (state_q)
        H_INIT: begin
          if (init_cnt_q == 32'(INIT_WAIT_CYCLES - 1)) begin
            state_q <= H_PRE_STOP;
          end else begin
            init_cnt_q <= init_cnt_q + 32'h00000001;
          end
        end
        H_PRE_STOP, H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            scl_q <= ph_q[1];
            oe_q <= ph_q[0] ^ ph_q[1];
            if (ph_q == 2'h3) begin
              state_q <= H_IDLE;
              init_done_q <= 1'b1;
            end
          end
        end
        H_IDLE: begin
          if (req_q) begin
            state_q <= H_START;
            kind_q <= req_kind_q;
            step_q <= 5'h00;
            last_q <= 1'b0;
            ph_q <= 2'h0;
          end
        end
        H_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            scl_q <= !ph_q[1];
            oe_q <= (ph_q != 2'h0);
            if (ph_q == 2'h3) begin
              state_q <= H_LOAD;
            end
          end
        end
        H_LOAD: begin
          if (frame_done) begin
            state_q <= H_STOP;
            ph_q <= 2'h0;
          end else if (!from_fifo || fifo_valid) begin
            cur_q <= from_fifo ? fifo_data[7:0] : seq_byte(kind_q, step_q);
            last_q <= from_fifo && fifo_data[TX_LAST_BIT];
            state_q <= H_BIT;
            bit_idx_q <= 4'h0;
            ph_q <= 2'h0;
          end
        end
        H_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            scl_q <= ph_q[0] ^ ph_q[1];
            if (ph_q == 2'h0) begin
              oe_q <= (bit_idx_q != 4'h8) && !cur_q[7];
            end
            if (ph_q == 2'h3 && bit_idx_q == 4'h8) begin
              step_q <= step_q + 5'h01;
              state_q <= H_LOAD;
            end else if (ph_q == 2'h3) begin
              bit_idx_q <= bit_idx_q + 4'h1;
              cur_q <= {cur_q[6:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  assign link.scl = scl_q;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = oe_q;
  assign hrdata_out = hrdata_q;
  assign hreadyout_out = hready_q;
  assign hresp_out = 1'b0;
endmodule
`default_nettype wire

// >>> tb/lcd_link_assertions.sv
// Purpose: link wire checks between host and driver ends
// Assumes: one clock; wires sampled on ref_clk_in
// Notes: ack and clock-phase timing only
`timescale 1ns/1ps
`default_nettype none
module lcd_link_assertions (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic scl,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic sda_line
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // ack edges fall in the clock's low phase
  AST_ACK_RISE: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("ack rose with clock high");
  AST_ACK_FALL: assert property ($fell(sda_dev_oe) |-> !scl)
    else $error("ack fell with clock high");
  // a move here would read as start or stop
  AST_ACK_STEADY: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("ack moved with clock high");
  AST_ACK_MIN: assert property ($rose(sda_dev_oe) |-> sda_dev_oe[*8])
    else $error("ack too short");
  AST_ACK_MAX: assert property ($rose(sda_dev_oe) |-> ##[1:400] !sda_dev_oe)
    else $error("ack held too long");
  // host lets go one quarter bit after the clock falls; overlap before that is legal
  AST_ACK_WIRE: assert property (sda_dev_oe && $past(sda_dev_oe, 100)
    |-> !sda_host_oe && !sda_line)
    else $error("ack not alone on wire");
  // both clock phases last several cycles
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high too short");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low too short");
endmodule
`default_nettype wire

// >>> tb/segment_lcd_command_sequencer_tb.sv
// Purpose: end-to-end bench, host and driver over the link
// Assumes: short init wait; status polled over AHB-Lite
// Notes: startup, full 18-byte data, display-off frames
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_command_sequencer_tb;
  import lcd_seq_pkg::*;
  logic ref_clk_in = 0;
  logic resetn_in = 0;
  logic hwrite = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata, r;
  logic hready, hresp, en, bias, inv, clock_source_select, a5;
  logic [5:0] ram_addr = 0;
  logic [5:0] sa;
  logic [3:0] ram_data;
  logic [1:0] fr, pw, bk, ap;
  int err_count = 0;
  int n_tests = 0;
  // all settings packed for one compare
  wire [18:0] cfg = {en, bias, fr, inv, pw, bk, ap, clock_source_select, a5, sa};
  lcd_link_if u_lcd_link_if ();
  // hready looped back: single slave
  lcd_cmd_host #(.INIT_WAIT_CYCLES(20)) u_lcd_cmd_host (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .link(u_lcd_link_if));
  lcd_cmd_device u_lcd_cmd_device (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .link(u_lcd_link_if),
    .ram_rd_addr_in(ram_addr), .ram_rd_data_out(ram_data), .display_enable_out(en),
    .bias_select_bit_out(bias), .frame_rate_sel_out(fr), .inversion_scheme_sel_out(inv),
    .power_level_sel_out(pw), .blink_rate_sel_out(bk), .all_pixel_mode_out(ap),
    .clock_source_select_out(clock_source_select), .address_high_bit_out(a5), .start_address_out(sa));
  lcd_link_assertions u_lcd_link_assertions (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .scl(u_lcd_link_if.scl),
    .sda_host_oe(u_lcd_link_if.sda_host_oe), .sda_dev_oe(u_lcd_link_if.sda_dev_oe),
    .sda_line(u_lcd_link_if.sda_line));
  always #4 ref_clk_in = ~ref_clk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk_in); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wait_st(input int b, input logic v);
    int k;
    for (k = 0; k < 30000; k++) begin
      ahb(0, STATUS_OFFSET, 32'h0);
      if (r[b] === v) return;
    end
    chk(r[b], v);
  endtask
  // read data lands one clock after the address
  task automatic ram_chk(input int a, input logic [3:0] e);
    ram_addr <= a[5:0];
    repeat (2) @(posedge ref_clk_in);
    chk(ram_data, e);
  endtask
  task automatic t_startup();
    wait_st(ST_INIT_BIT, 1'b1);
    chk(cfg, 19'h02000);
    ahb(1, CTRL_OFFSET, 32'h1);
    wait_st(ST_BUSY_BIT, 1'b0);
    chk(cfg, 19'h5c000);
    ahb(0, STATUS_OFFSET, 32'h0);
    chk(r[ST_NACK_BIT], 0);
  endtask
  // a full 18-byte frame fills the RAM; the FIFO stalls the bus meanwhile
  task automatic t_data();
    int i;
    ahb(1, CTRL_OFFSET, 32'h4);
    for (i = 0; i < MAX_DATA_BYTES; i++)
      ahb(1, TX_OFFSET, {23'h0, i == MAX_DATA_BYTES - 1, ~i[3:0], i[3:0]});
    wait_st(ST_BUSY_BIT, 1'b0);
    for (i = 0; i < 36; i++)
      ram_chk(i, i[0] ? ~i[4:1] : i[4:1]);
    chk(cfg, 19'h5c000);
    ahb(0, STATUS_OFFSET, 32'h0);
    chk(r[ST_NACK_BIT], 0);
    ahb(1, STATUS_OFFSET, 32'h4);
    ahb(0, STATUS_OFFSET, 32'h0);
    chk(r[ST_NACK_BIT], 0);
    chk(r[ST_ROOM_BIT], 1);
  endtask
  task automatic t_off();
    ahb(1, CTRL_OFFSET, 32'h2);
    wait_st(ST_BUSY_BIT, 1'b0);
    chk(cfg, 19'h1c000);
    ahb(0, 8'h0c, 32'h0);
    chk(r, 32'h0);
    chk(hresp, 0);
  endtask
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t_startup();
    t_data();
    t_off();
    end_of_test();
  end
  // frames take about 79k cycles in all; margin for polling
  initial begin
    repeat (95000) @(posedge ref_clk_in);
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
